// ### inc/fps_pkg.sv
package fps_pkg;
   // ==========================================
   // Register map
   localparam int ADDR_W = 16;
   localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h5B30;
   localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
   localparam int NUM_FN = 3;  // Functions 2, 3, 4
   // ==========================================
   // Field positions
   localparam int MGMT_GATED_BIT = 29;
   localparam int RSVD_HI_BIT = 28;
   localparam int FN4_AUX_BIT = 27;
   localparam int PLAT_EN_BIT = 26;
   localparam int FN4_PWR_LSB = 24;
   localparam int FN3_AUX_BIT = 21;
   localparam int SER_EN_BIT = 20;
   localparam int FN3_PWR_LSB = 18;
   localparam int FN2_AUX_BIT = 15;
   localparam int DISK_EN_BIT = 14;
   localparam int FN2_PWR_LSB = 12;
   // Holes in 28..10 reserved; bits 31:30 and 9:0 are not in this mask
   localparam logic [31:0] RSVD_MASK = 32'h10C3_0C00;
   localparam logic [31:0] LIVE_MASK = 32'h2F3C_F000;
   // ==========================================
   // Nonvolatile load
   localparam logic [7:0] NVM_WORD_MULTI = 8'h21;
   localparam logic [7:0] NVM_WORD_SINGLE = 8'h49;
   localparam int NVM_PLAT_BIT = 12;
   localparam int NVM_SER_BIT = 13;
   localparam int NVM_DISK_BIT = 14;
   // ==========================================
   // Bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_DECERR = 2'h3;
   typedef enum logic [1:0] {
      PWR_DR,
      PWR_D0_UNINIT,
      PWR_D0_ACTIVE,
      PWR_D3
   } pwr_state_t;
endpackage

// ### inc/fn_stat_if.sv
`timescale 1ns/10ps
`default_nettype none
interface fn_stat_if;
   import fps_pkg::*;
   logic [NUM_FN-1:0] aux_raw;
   logic [NUM_FN-1:0][1:0] pwr_raw;
   logic [NUM_FN-1:0] aux_q;
   logic [NUM_FN-1:0][1:0] pwr_q;
   modport src (input aux_raw, input pwr_raw, output aux_q, output pwr_q);
   modport dst (output aux_raw, output pwr_raw, input aux_q, input pwr_q);
endinterface
`default_nettype wire

// ### design/fn_power_capture.sv
`timescale 1ns/10ps
`default_nettype none
module fn_power_capture (
   input wire logic aclk,    // Core clock
   input wire logic aresetn, // Sync reset, low
   fn_stat_if.src st         // Per-function state
);
   import fps_pkg::*;
   // ==========================================
   // One shadow per function, index 0 is function 2
   for (genvar i = 0; i < NUM_FN; i++) begin : g_fn
      always_ff @(posedge aclk) begin
         if (!aresetn) begin
            st.aux_q[i] <= 1'b0;
            st.pwr_q[i] <= 2'h0;
         end else begin
            st.aux_q[i] <= st.aux_raw[i];
            st.pwr_q[i] <= st.pwr_raw[i];
         end
      end
   end
endmodule
`default_nettype wire

// ### design/function_power_status_bits.sv
// Decided for this implementation: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module function_power_status_bits (
   input wire logic aclk,                         // Core clock
   input wire logic aresetn,                      // Sync reset, low
   input wire logic mgmt_clk_gated,               // Manageability clock gated
   input wire logic [fps_pkg::NUM_FN-1:0] aux_pm_en, // Aux PM enable, fn 2..4
   input wire logic [1:0] fn2_pwr,                // Fn 2 power state
   input wire logic [1:0] fn3_pwr,                // Fn 3 power state
   input wire logic [1:0] fn4_pwr,                // Fn 4 power state
   input wire logic single_port_variant,          // Selects NVM word
   input wire logic nvm_word_valid,               // NVM word strobe
   input wire logic [7:0] nvm_word_addr,          // NVM word address
   input wire logic [15:0] nvm_word_data,         // NVM word data
   input wire logic [fps_pkg::ADDR_W-1:0] awaddr, // AXI write address
   input wire logic awvalid,                      // AXI
   output logic awready,                          // AXI
   input wire logic [31:0] wdata,                 // AXI, ignored
   input wire logic [3:0] wstrb,                  // AXI, ignored
   input wire logic wvalid,                       // AXI
   output logic wready,                           // AXI
   output logic [1:0] bresp,                      // AXI
   output logic bvalid,                           // AXI
   input wire logic bready,                       // AXI
   input wire logic [fps_pkg::ADDR_W-1:0] araddr, // AXI read address
   input wire logic arvalid,                      // AXI
   output logic arready,                          // AXI
   output logic [31:0] rdata,                     // AXI
   output logic [1:0] rresp,                      // AXI
   output logic rvalid,                           // AXI
   input wire logic rready                        // AXI
);
   import fps_pkg::*;

   logic mgmt_gated_q;
   logic plat_en_q;
   logic ser_en_q;
   logic disk_en_q;
   logic awready_q;
   logic wready_q;
   logic aw_got_q;
   logic w_got_q;
   logic aw_hit_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic arready_q;
   logic rvalid_q;
   logic [1:0] rresp_q;
   logic [31:0] rdata_q;
   logic [31:0] status_word;
   logic nvm_hit;
   logic aw_fire;
   logic w_fire;
   logic ar_fire;
   logic ar_hit;

   fn_stat_if st ();

   assign st.aux_raw = aux_pm_en;
   assign st.pwr_raw = {fn4_pwr, fn3_pwr, fn2_pwr};

   fn_power_capture u_capture (
      .aclk(aclk),
      .aresetn(aresetn),
      .st(st)
   );

   // ==========================================
   // Status sources
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mgmt_gated_q <= 1'b0;
      end else begin
         mgmt_gated_q <= mgmt_clk_gated;
      end
   end

   // Enables only change on a load of the selected word
   assign nvm_hit = nvm_word_valid &&
      (nvm_word_addr == (single_port_variant ? NVM_WORD_SINGLE : NVM_WORD_MULTI));

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         plat_en_q <= 1'b0;
         ser_en_q <= 1'b0;
         disk_en_q <= 1'b0;
      end else if (nvm_hit) begin
         plat_en_q <= nvm_word_data[NVM_PLAT_BIT];
         ser_en_q <= nvm_word_data[NVM_SER_BIT];
         disk_en_q <= nvm_word_data[NVM_DISK_BIT];
      end
   end

   // ==========================================
   // Register assembly; unassigned bits stay zero
   always_comb begin
      status_word = STATUS_RESET;
      status_word[MGMT_GATED_BIT] = mgmt_gated_q;
      status_word[FN4_AUX_BIT] = st.aux_q[2];
      status_word[PLAT_EN_BIT] = plat_en_q;
      status_word[FN4_PWR_LSB +: 2] = st.pwr_q[2];
      status_word[FN3_AUX_BIT] = st.aux_q[1];
      status_word[SER_EN_BIT] = ser_en_q;
      status_word[FN3_PWR_LSB +: 2] = st.pwr_q[1];
      status_word[FN2_AUX_BIT] = st.aux_q[0];
      status_word[DISK_EN_BIT] = disk_en_q;
      status_word[FN2_PWR_LSB +: 2] = st.pwr_q[0];
   end

   // ==========================================
   // AXI write side: read-only register, data dropped
   assign aw_fire = awvalid && awready_q;
   assign w_fire = wvalid && wready_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         awready_q <= 1'b0;
         wready_q <= 1'b0;
         aw_got_q <= 1'b0;
         w_got_q <= 1'b0;
         aw_hit_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else begin
         if (aw_fire) begin
            aw_got_q <= 1'b1;
            awready_q <= 1'b0;
            aw_hit_q <= (awaddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]);
         end else if (!aw_got_q && !bvalid_q) begin
            awready_q <= 1'b1;
         end
         if (w_fire) begin
            w_got_q <= 1'b1;
            wready_q <= 1'b0;
         end else if (!w_got_q && !bvalid_q) begin
            wready_q <= 1'b1;
         end
         if (aw_got_q && w_got_q && !bvalid_q) begin
            bvalid_q <= 1'b1;
            // Hit is acknowledged but changes nothing
            bresp_q <= aw_hit_q ? RESP_OKAY : RESP_DECERR;
            aw_got_q <= 1'b0;
            w_got_q <= 1'b0;
         end else if (bvalid_q && bready) begin
            bvalid_q <= 1'b0;
         end
      end
   end

   // ==========================================
   // AXI read side
   assign ar_fire = arvalid && arready_q;
   assign ar_hit = (araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rresp_q <= RESP_OKAY;
         rdata_q <= STATUS_RESET;
      end else if (ar_fire) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= ar_hit ? RESP_OKAY : RESP_DECERR;
         rdata_q <= ar_hit ? status_word : STATUS_RESET;
      end else if (rvalid_q && rready) begin
         rvalid_q <= 1'b0;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   assign awready = awready_q;
   assign wready = wready_q;
   assign bvalid = bvalid_q;
   assign bresp = bresp_q;
   assign arready = arready_q;
   assign rvalid = rvalid_q;
   assign rresp = rresp_q;
   assign rdata = rdata_q;

   // ==========================================
   // Checks
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence s_rd_hit;
      arvalid && arready && (araddr[ADDR_W-1:2] == STATUS_ADDR[ADDR_W-1:2]);
   endsequence
   sequence s_rd_answer;
      ##1 rvalid && (rresp == RESP_OKAY);
   endsequence

   a_mgmt_flag: assert property ($past(aresetn) |->
      mgmt_gated_q == $past(mgmt_clk_gated))
      else $error("gated flag does not follow input");
   a_fn4_aux: assert property (##1 status_word[FN4_AUX_BIT] == $past(aux_pm_en[2]))
      else $error("fn4 aux shadow wrong");
   a_fn3_aux: assert property (##1 status_word[FN3_AUX_BIT] == $past(aux_pm_en[1]))
      else $error("fn3 aux shadow wrong");
   a_fn2_aux: assert property (##1 status_word[FN2_AUX_BIT] == $past(aux_pm_en[0]))
      else $error("fn2 aux shadow wrong");
   a_pwr_fields: assert property (##1 status_word[FN4_PWR_LSB +: 2] == $past(fn4_pwr) &&
      status_word[FN3_PWR_LSB +: 2] == $past(fn3_pwr) &&
      status_word[FN2_PWR_LSB +: 2] == $past(fn2_pwr))
      else $error("power state field wrong");
   a_en_load: assert property (nvm_hit |=>
      plat_en_q == $past(nvm_word_data[NVM_PLAT_BIT]) &&
      ser_en_q == $past(nvm_word_data[NVM_SER_BIT]) &&
      disk_en_q == $past(nvm_word_data[NVM_DISK_BIT]))
      else $error("enable bits not loaded");
   a_en_hold: assert property (!nvm_hit |=> $stable({plat_en_q, ser_en_q, disk_en_q}))
      else $error("enable bits changed without load");
   a_ser_word: assert property (nvm_word_valid && nvm_word_addr == NVM_WORD_SINGLE &&
      !single_port_variant |=> $stable(ser_en_q))
      else $error("serial enable loaded from wrong word");
   // Checked on the bus output, so a stray bit anywhere on the read path shows
   a_rsvd_zero: assert property ((rdata & ~LIVE_MASK) == 32'h0000_0000)
      else $error("reserved bit set");
   a_rd_data: assert property (s_rd_hit |-> s_rd_answer ##0
      rdata == $past(status_word))
      else $error("read data wrong");
   a_wr_ignored: assert property (w_fire && !nvm_hit |=>
      $stable({plat_en_q, ser_en_q, disk_en_q}) && mgmt_gated_q == $past(mgmt_clk_gated))
      else $error("write disturbed register");
   a_pwr_codes: assert property (fn2_pwr == 2'h3 |=>
      status_word[FN2_PWR_LSB +: 2] == 2'(PWR_D3))
      else $error("power code remapped");
   a_fn3_pwr: assert property (##1 status_word[FN3_PWR_LSB +: 2] == $past(fn3_pwr))
      else $error("fn3 power state wrong");
endmodule
`default_nettype wire

// ### verif/tb_function_power_status_bits.sv
`timescale 1ns/10ps
`default_nettype none
module tb_function_power_status_bits;
   import fps_pkg::*;
   // ==========================================
   // Stimulus and bus signals
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic mgmt_clk_gated = 1'b0;
   logic [NUM_FN-1:0] aux_pm_en = '0;
   logic [1:0] fn2_pwr = 2'h0;
   logic [1:0] fn3_pwr = 2'h0;
   logic [1:0] fn4_pwr = 2'h0;
   logic single_port_variant = 1'b0;
   logic nvm_word_valid = 1'b0;
   logic [7:0] nvm_word_addr = 8'h00;
   logic [15:0] nvm_word_data = 16'h0000;
   logic [ADDR_W-1:0] awaddr = '0;
   logic [ADDR_W-1:0] araddr = '0;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [2:0] en_exp = 3'h0;  // Expected enables: bit 26, 20, 14
   int errors = 0;
   int checked = 0;
   int cycles = 0;

   function_power_status_bits u_dut (
      .aclk, .aresetn, .mgmt_clk_gated, .aux_pm_en, .fn2_pwr, .fn3_pwr, .fn4_pwr,
      .single_port_variant, .nvm_word_valid, .nvm_word_addr, .nvm_word_data,
      .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
      .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready
   );

   always #10 aclk = ~aclk;

   // ==========================================
   // Hang guard, far above the hundred or so cycles needed
   always @(posedge aclk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         errors++;
         wrap_up();
      end
   end

   task automatic wrap_up();
      $display("Checks %0d, errors %0d", checked, errors);
      if (errors == 0 && checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   function automatic logic [31:0] exp_word();
      return {2'h0, mgmt_clk_gated, 1'b0, aux_pm_en[2], en_exp[2], fn4_pwr, 2'h0,
              aux_pm_en[1], en_exp[1], fn3_pwr, 2'h0, aux_pm_en[0], en_exp[0], fn2_pwr, 12'h000};
   endfunction

   // ==========================================
   // Bus tasks
   task automatic read_expect(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
      arvalid <= 1'b1;
      araddr <= a;
      rready <= 1'b1;
      do @(posedge aclk); while (arready !== 1'b1);
      arvalid <= 1'b0;
      do @(posedge aclk); while (rvalid !== 1'b1);
      check(rdata, ed);
      check({30'h0, rresp}, {30'h0, er});
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic write_expect(input logic [15:0] a, input logic [31:0] d, input logic [1:0] er);
      logic aw_done;
      logic w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      bready <= 1'b1;
      while (!(aw_done && w_done)) begin
         @(posedge aclk);
         if (awready === 1'b1) begin
            aw_done = 1'b1;
            awvalid <= 1'b0;
         end
         if (wready === 1'b1) begin
            w_done = 1'b1;
            wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (bvalid !== 1'b1);
      check({30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic nvm_load(input logic [7:0] a, input logic [15:0] d);
      nvm_word_valid <= 1'b1;
      nvm_word_addr <= a;
      nvm_word_data <= d;
      @(posedge aclk);
      nvm_word_valid <= 1'b0;
      repeat (2) @(posedge aclk);
   endtask

   // ==========================================
   // Main sequence
   initial begin
      repeat (12) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      read_expect(STATUS_ADDR, 32'h0, RESP_OKAY);
      for (int i = 0; i < 4; i++) begin
         mgmt_clk_gated <= i[0];
         aux_pm_en <= {i[0], i[1], ~i[0]};
         fn2_pwr <= 2'(i);
         fn3_pwr <= 2'(i + 1);
         fn4_pwr <= 2'(i + 2);
         repeat (2) @(posedge aclk);
         read_expect(STATUS_ADDR, exp_word(), RESP_OKAY);
      end
      nvm_load(NVM_WORD_MULTI, 16'h7000);
      en_exp = 3'b111;
      read_expect(STATUS_ADDR, exp_word(), RESP_OKAY);
      // Other variant's word must be ignored
      nvm_load(NVM_WORD_SINGLE, 16'h0000);
      read_expect(STATUS_ADDR, exp_word(), RESP_OKAY);
      single_port_variant <= 1'b1;
      nvm_load(NVM_WORD_MULTI, 16'h0000);
      read_expect(STATUS_ADDR, exp_word(), RESP_OKAY);
      for (int k = 0; k < 3; k++) begin
         nvm_load(NVM_WORD_SINGLE, 16'h1000 << k);
         en_exp = 3'b100 >> k;
         read_expect(STATUS_ADDR, exp_word(), RESP_OKAY);
      end
      mgmt_clk_gated <= 1'b1;
      aux_pm_en <= 3'b111;
      fn2_pwr <= 2'h3;
      fn3_pwr <= 2'h3;
      fn4_pwr <= 2'h3;
      write_expect(STATUS_ADDR, 32'hFFFF_FFFF, RESP_OKAY);
      read_expect(STATUS_ADDR, exp_word(), RESP_OKAY);
      write_expect(STATUS_ADDR + 16'h4, 32'hFFFF_FFFF, RESP_DECERR);
      read_expect(STATUS_ADDR + 16'h4, 32'h0, RESP_DECERR);
      // Second reset in mid-run clears the loaded enables too
      aresetn <= 1'b0;
      mgmt_clk_gated <= 1'b0;
      aux_pm_en <= 3'b000;
      fn2_pwr <= 2'h0;
      fn3_pwr <= 2'h0;
      fn4_pwr <= 2'h0;
      repeat (3) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (2) @(posedge aclk);
      read_expect(STATUS_ADDR, 32'h0, RESP_OKAY);
      wrap_up();
   end
endmodule
`default_nettype wire
